// *** test/tb_uart_receive_buffer_flags.sv ***
`timescale 1ns/100ps
module tb_uart_receive_buffer_flags;
   typedef struct packed {logic [7:0] f; logic [8:0] d; logic [3:0] n; logic pv; logic s; logic [7:0] xd, xs, xc;} urb_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, pin, ovr, sout, start, strobe, bv, irq, er;
   logic [7:0] rv;
   int err_total = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] ov [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
   urb_row_t rows [7] = '{
      '{8'h06, 9'h0A5, 4'h8, 1'b0, 1'b1, 8'hA5, 8'h80, 8'h90},
      '{8'h00, 9'h1F7, 4'h5, 1'b0, 1'b1, 8'h17, 8'h80, 8'h90},
      '{8'h01, 9'h02A, 4'h6, 1'b0, 1'b0, 8'h2A, 8'h90, 8'h90},
      '{8'h02, 9'h07F, 4'h7, 1'b0, 1'b1, 8'h7F, 8'h80, 8'h90},
      '{8'h26, 9'h03C, 4'h8, 1'b1, 1'b1, 8'h3C, 8'h84, 8'h90},
      '{8'h36, 9'h001, 4'h8, 1'b0, 1'b1, 8'h01, 8'h80, 8'h90},
      '{8'h07, 9'h1C3, 4'h9, 1'b0, 1'b1, 8'hC3, 8'h80, 8'h92}};
   urb_rx_buffer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(pin),
      .rx_pin_override(ovr), .rx_serial_out(sout), .rx_start_seen(start), .rx_bit_strobe(strobe),
      .rx_bit_value(bv), .rx_irq_req(irq));
   urb_tx_model u_tx (.pclk(pclk), .start(start), .strobe(strobe), .bit_val(bv), .pin(pin));
   initial begin
      forever #10 pclk = ~pclk;
   end
   task automatic final_report;
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         final_report;
      end
   end
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00, rv, er);
      chk_byte(rv, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, rv, er);
   endtask
   task automatic send(input logic [7:0] d);
      u_tx.frame({1'b0, d}, 8, 1'b0, 1'b0, 1'b1);
      repeat (4) @(posedge pclk);
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h0C, 8'h06);
      wr(8'h08, 8'h90);
      repeat (2) @(posedge pclk);
      chk_bit(ovr, 1'b1);
      foreach (rows[i]) begin
         wr(8'h0C, rows[i].f);
         u_tx.frame(rows[i].d, rows[i].n, rows[i].f[5], rows[i].pv, rows[i].s);
         repeat (4) @(posedge pclk);
         chk_bit(irq, 1'b1);
         rd_chk(8'h04, rows[i].xs);
         rd_chk(8'h08, rows[i].xc);
         rd_chk(8'h00, rows[i].xd);
         rd_chk(8'h04, 8'h00);
      end
      wr(8'h0C, 8'h06);
      // A second stop bit strobed low must not mark a frame error
      u_tx.frame(9'h05A, 8, 1'b0, 1'b0, 1'b1);
      u_tx.put(1'b0);
      repeat (4) @(posedge pclk);
      rd_chk(8'h04, 8'h80);
      rd_chk(8'h00, 8'h5A);
      // Stored parity error is hidden while checking is off, kept until read
      wr(8'h0C, 8'h26);
      u_tx.frame(9'h03C, 8, 1'b1, 1'b1, 1'b1);
      repeat (4) @(posedge pclk);
      wr(8'h0C, 8'h06);
      rd_chk(8'h04, 8'h80);
      wr(8'h0C, 8'h26);
      rd_chk(8'h04, 8'h84);
      wr(8'h0C, 8'h06);
      rd_chk(8'h00, 8'h3C);
      foreach (ov[i]) send(ov[i]);
      rd_chk(8'h04, 8'h80);
      rd_chk(8'h00, 8'h11);
      rd_chk(8'h00, 8'h22);
      wr(8'h04, 8'h00);
      rd_chk(8'h04, 8'h88);
      rd_chk(8'h00, 8'h44);
      send(8'h55);
      send(8'h66);
      rd_chk(8'h04, 8'h80);
      rd_chk(8'h00, 8'h55);
      rd_chk(8'h00, 8'h66);
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h00, 8'h00);
      send(8'h77);
      fork
         u_tx.frame(9'h0EE, 8, 1'b0, 1'b0, 1'b1);
         begin
            repeat (6) @(posedge pclk);
            wr(8'h08, 8'h00);
         end
      join
      rd_chk(8'h04, 8'h00);
      chk_bit(irq, 1'b0);
      chk_bit(ovr, 1'b0);
      chk_bit(sout, 1'b1);
      wr(8'h08, 8'h90);
      send(8'hE1);
      rd_chk(8'h00, 8'hE1);
      // Reset in mid-run returns the receiver to its disabled defaults
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk_bit(ovr, 1'b0);
      chk_bit(sout, 1'b1);
      chk_bit(irq, 1'b0);
      presetn <= 1'b1;
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h0C, 8'h06);
      rd_chk(8'h04, 8'h00);
      apb(1'b0, 8'h10, 8'h00, rv, er);
      chk_bit(er, 1'b1);
      final_report;
   end
endmodule

// *** test/urb_rx_monitor.sv ***
`timescale 1ns/100ps
module urb_rx_monitor #(
   parameter AW = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [AW-1:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire serial_in_pin,
   input wire rx_pin_override,
   input wire rx_serial_out,
   input wire rx_irq_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   chk_ready_after_setup: assert property (setup_s ##1 access_s |-> pready) else $error("ready missing");
   chk_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
   chk_ready_in_access: assert property (pready |-> access_s) else $error("ready outside access");
   chk_err_decode: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
      else $error("bad error flag");
   chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   chk_irq_holds: assert property (rx_irq_req && !pready && !$past(pready) |=> rx_irq_req)
      else $error("irq dropped");
   chk_irq_off_disabled: assert property ($fell(rx_pin_override) |=> !rx_irq_req)
      else $error("irq after disable");
   chk_pin_released: assert property (!rx_pin_override && !$past(rx_pin_override) |-> rx_serial_out)
      else $error("pin not released");
   chk_pin_follows: assert property (rx_pin_override && $past(rx_pin_override, 4) |->
      rx_serial_out == $past(serial_in_pin, 3))
      else $error("pin not followed");
endmodule
bind urb_rx_buffer urb_rx_monitor #(.AW(AW)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
   .rx_pin_override(rx_pin_override), .rx_serial_out(rx_serial_out), .rx_irq_req(rx_irq_req));

// *** test/urb_tx_model.sv ***
`timescale 1ns/100ps
module urb_tx_model (
   input wire pclk,
   output logic start,
   output logic strobe,
   output logic bit_val,
   output logic pin
);
   initial begin
      start = 1'b0;
      strobe = 1'b0;
      bit_val = 1'b0;
      pin = 1'b1;
   end
   // Bit value is only valid with its strobe, so it flips afterwards
   task automatic put(input logic b);
      @(posedge pclk);
      strobe <= 1'b1;
      bit_val <= b;
      pin <= b;
      @(posedge pclk);
      strobe <= 1'b0;
      bit_val <= ~b;
   endtask
   // Only the first stop bit is strobed here; a second stop bit needs its own put
   task automatic frame(input logic [8:0] d, input int n, input logic pe, input logic pv, input logic stp);
      @(posedge pclk);
      start <= 1'b1;
      pin <= 1'b0;
      @(posedge pclk);
      start <= 1'b0;
      for (int i = 0; i < n; i++) put(d[i]);
      if (pe) put(pv);
      put(stp);
      pin <= 1'b1;
   endtask
endmodule

// *** verilog/urb_map.vh ***
`ifndef URB_MAP_VH
`define URB_MAP_VH

// Register byte offsets
`define URB_OFF_DATA 8'h00
`define URB_OFF_STATUS 8'h04
`define URB_OFF_CONTROL 8'h08
`define URB_OFF_FORMAT 8'h0C

// rx_status_reg fields
`define URB_ST_RXC 7
`define URB_ST_FE 4
`define URB_ST_DOR 3
`define URB_ST_PE 2

// rx_control_reg fields
`define URB_CT_IRQ_EN 7
`define URB_CT_RX_EN 4
`define URB_CT_RX9 1
`define URB_CT_TX9 0

// frame_format_reg fields
`define URB_FF_PAR_EN 5
`define URB_FF_PAR_ODD 4
`define URB_FF_STOP 3
`define URB_FF_CS_HI 2
`define URB_FF_CS_LO 0

// Reset values
`define URB_RST_CONTROL 8'h00
`define URB_RST_FORMAT 8'h06
`define URB_RST_CS 3'h6

// Character size code for nine-bit characters
`define URB_CS_NINE 3'h7

// Buffer entry layout
`define URB_EN_PE 11
`define URB_EN_DOR 10
`define URB_EN_FE 9
`define URB_EN_B8 8

`endif

// *** verilog/urb_rx_buffer.v ***
// What this block does
// - Data read pops entry, flags follow next.
// - Complete flag set while buffer holds data.
// - Disable flushes buffer, clears complete flag.
// - Interrupt request while enabled and complete.
// - Every entry keeps its own error bits.
// - Status writes never alter error flags.
// - Error flags never request an interrupt.
// - Frame error means first stop sampled low.
// - Only first stop bit is checked.
// - Overrun when full, held, new start.
// - Overrun clears on successful buffer transfer.
// - Parity error reads zero when checking off.
// - Parity checked when enabled, odd/even selectable.
// - Parity result stored per entry until read.
// - Disable is immediate, reception in progress lost.
// - Disabled receiver releases the serial pin.
// - First stop bit moves frame into hold, then buffer when space.
// - Unused upper data bits read zero.
// - Enable hands serial pin to the receiver.
`timescale 1ns/100ps
`include "urb_map.vh"

module urb_rx_buffer #(
   parameter DEPTH = 2,
   parameter AW = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire serial_in_pin,
   output reg rx_pin_override,
   output reg rx_serial_out,
   input wire rx_start_seen,
   input wire rx_bit_strobe,
   input wire rx_bit_value,
   output reg rx_irq_req
);

   localparam ST_IDLE = 2'd0;
   localparam ST_DATA = 2'd1;
   localparam ST_PAR = 2'd2;
   localparam ST_STOP = 2'd3;

   // Data bits per character for a size code; reserved codes act as eight
   function [3:0] char_bits;
      input [2:0] cs;
      begin
         if (cs == `URB_CS_NINE)
            char_bits = 4'd9;
         else if (cs[2])
            char_bits = 4'd8;
         else
            char_bits = 4'd5 + {2'b00, cs[1:0]};
      end
   endfunction

   // Clears the bits above the character width
   function [8:0] mask_bits;
      input [8:0] d;
      input [3:0] n;
      integer i;
      begin
         for (i = 0; i < 9; i = i + 1)
            mask_bits[i] = d[i] & (i < n);
      end
   endfunction

   // Buffer storage; pointers and count are sized for two entries,
   // so a deeper buffer needs wider pointers and a wider count
   reg [11:0] mem_q [0:DEPTH-1];
   reg [0:0] wr_q;
   reg [0:0] rd_q;
   reg [1:0] cnt_q;

   // Receive sequencer and held frame
   reg [1:0] st_q;
   reg [3:0] bit_q;
   reg [8:0] sh_q;
   reg par_q;
   reg [10:0] hold_q;
   reg hold_v_q;
   reg dor_pend_q;

   // Software settings
   reg irq_en_q;
   reg rx_en_q;
   reg tx9_q;
   reg par_en_q;
   reg par_odd_q;
   reg stop_sel_q;
   reg [2:0] cs_q;

   // Pin synchroniser and read bookkeeping
   reg pin_s1_q;
   reg pin_s2_q;
   reg pop_pend_q;
   integer k;

   wire setup = psel & ~penable;
   // Writes and pops commit only on the access edge
   wire acc = psel & penable & pready;
   wire wr_en = acc & pwrite;
   wire [3:0] nbits = char_bits(cs_q);
   wire nine = (cs_q == `URB_CS_NINE);
   wire [11:0] head = mem_q[rd_q];
   wire not_empty = (cnt_q != 2'd0);
   wire full = (cnt_q == 2'd2);
   // Pop only if the value returned at setup came from a real entry
   wire pop = acc & ~pwrite & pop_pend_q & not_empty;
   wire push = hold_v_q & rx_en_q & (~full | pop);
   // The frame already held is the one dropped; the new start proceeds
   // overrun detection
   wire ovr = rx_en_q & rx_start_seen & (st_q == ST_IDLE) & hold_v_q & full & ~pop;
   // Counter runs from zero, so the last data bit is one below the size
   wire last_data = (bit_q == nbits - 4'd1);
   wire par_exp = (^mask_bits(sh_q, nbits)) ^ par_odd_q;
   // Bits above the character size are cleared before storage
   wire [8:0] frame = mask_bits(sh_q, nbits);

   // Pin sampled through two flops before use
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
      end else begin
         pin_s1_q <= serial_in_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   // Register file and APB response
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_q <= 1'b0;
         rx_en_q <= 1'b0;
         tx9_q <= 1'b0;
         par_en_q <= 1'b0;
         par_odd_q <= 1'b0;
         stop_sel_q <= 1'b0;
         cs_q <= `URB_RST_CS;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         pop_pend_q <= 1'b0;
      end else begin
         // No wait states: pready is a one-cycle echo of the setup cycle
         pready <= setup;
         if (setup) begin
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            pop_pend_q <= 1'b0;
            case (paddr)
               `URB_OFF_DATA: begin
                  // An empty read returns zero and leaves the pointers alone
                  if (!pwrite && not_empty) begin
                     prdata[7:0] <= head[7:0];
                     pop_pend_q <= 1'b1;
                  end
               end
               `URB_OFF_STATUS: begin
                  prdata[`URB_ST_RXC] <= not_empty;
                  prdata[`URB_ST_FE] <= not_empty & head[`URB_EN_FE];
                  prdata[`URB_ST_DOR] <= not_empty & head[`URB_EN_DOR];
                  // parity error hidden when checking off
                  prdata[`URB_ST_PE] <= not_empty & head[`URB_EN_PE] & par_en_q;
               end
               `URB_OFF_CONTROL: begin
                  prdata[`URB_CT_IRQ_EN] <= irq_en_q;
                  prdata[`URB_CT_RX_EN] <= rx_en_q;
                  prdata[`URB_CT_RX9] <= not_empty & head[`URB_EN_B8];
                  prdata[`URB_CT_TX9] <= tx9_q;
               end
               `URB_OFF_FORMAT: begin
                  prdata[`URB_FF_PAR_EN] <= par_en_q;
                  prdata[`URB_FF_PAR_ODD] <= par_odd_q;
                  prdata[`URB_FF_STOP] <= stop_sel_q;
                  prdata[`URB_FF_CS_HI:`URB_FF_CS_LO] <= cs_q;
               end
               default: begin
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (wr_en) begin
            case (paddr)
               `URB_OFF_CONTROL: begin
                  // Received ninth bit is read-only; only the transmit copy is stored
                  irq_en_q <= pwdata[`URB_CT_IRQ_EN];
                  rx_en_q <= pwdata[`URB_CT_RX_EN];
                  tx9_q <= pwdata[`URB_CT_TX9];
               end
               `URB_OFF_FORMAT: begin
                  par_en_q <= pwdata[`URB_FF_PAR_EN];
                  par_odd_q <= pwdata[`URB_FF_PAR_ODD];
                  stop_sel_q <= pwdata[`URB_FF_STOP];
                  cs_q <= pwdata[`URB_FF_CS_HI:`URB_FF_CS_LO];
               end
               // status and data writes change nothing here
               default: begin
                  pop_pend_q <= pop_pend_q;
               end
            endcase
         end
      end
   end

   // Receive shift register and frame sequencing
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         bit_q <= 4'd0;
         sh_q <= 9'h000;
         par_q <= 1'b0;
         hold_q <= 11'h000;
         hold_v_q <= 1'b0;
         dor_pend_q <= 1'b0;
      end else if (!rx_en_q) begin
         // Disable beats push, overrun and strobes in the same cycle
         // abandon reception at once
         st_q <= ST_IDLE;
         bit_q <= 4'd0;
         hold_v_q <= 1'b0;
         dor_pend_q <= 1'b0;
      end else begin
         if (push) begin
            hold_v_q <= 1'b0;
            dor_pend_q <= 1'b0;
         end
         if (ovr) begin
            hold_v_q <= 1'b0;
            dor_pend_q <= 1'b1;
         end
         case (st_q)
            ST_IDLE: begin
               if (rx_start_seen) begin
                  st_q <= ST_DATA;
                  bit_q <= 4'd0;
                  sh_q <= 9'h000;
               end
            end
            ST_DATA: begin
               // Bits arrive LSB first, each into its own position
               if (rx_bit_strobe) begin
                  sh_q[bit_q] <= rx_bit_value;
                  bit_q <= bit_q + 4'd1;
                  if (last_data)
                     st_q <= par_en_q ? ST_PAR : ST_STOP;
               end
            end
            ST_PAR: begin
               if (rx_bit_strobe) begin
                  par_q <= rx_bit_value;
                  st_q <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (rx_bit_strobe) begin
                  st_q <= ST_IDLE;
                  hold_v_q <= 1'b1;
                  hold_q[7:0] <= frame[7:0];
                  // Ninth bit kept only in nine-bit mode, so narrow frames never set it
                  hold_q[`URB_EN_B8] <= nine & frame[8];
                  // stop sampled low marks frame error
                  hold_q[`URB_EN_FE] <= ~rx_bit_value;
                  hold_q[10] <= par_en_q & (par_q != par_exp);
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Two-entry receive buffer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'd0;
         for (k = 0; k < DEPTH; k = k + 1)
            mem_q[k] <= 12'h000;
      end else if (!rx_en_q) begin
         // Storage keeps stale words after a flush; the count alone says what is valid
         // flush on disable
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cnt_q <= 2'd0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= {hold_q[10], dor_pend_q, hold_q[9:0]};
            wr_q <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'd1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'd1;
      end
   end

   // Pin hand-over and interrupt request
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_pin_override <= 1'b0;
         rx_serial_out <= 1'b1;
         rx_irq_req <= 1'b0;
      end else begin
         // Output idles high while disabled so the recovery unit sees a quiet line
         // pin released while disabled
         rx_pin_override <= rx_en_q;
         rx_serial_out <= rx_en_q ? pin_s2_q : 1'b1;
         // level request from fill level only
         rx_irq_req <= irq_en_q & rx_en_q & not_empty;
      end
   end

endmodule
